// [rtl/irq_ctrl_pkg.sv]
// Constants and register map of the two-level interrupt controller
package irq_ctrl_pkg;

    // ********************************************************
    // Machine cycle timing
    // ********************************************************
    localparam logic [3:0] PHASE_LAST   = 4'hB;  // 12 clocks per cycle
    localparam logic [3:0] PHASE_SAMPLE = 4'h9;  // State 5, phase 2
    localparam logic [1:0] CALL_CYCLES  = 2'h2;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [4:0] OFS_LEVEL  = 5'h00;
    localparam logic [4:0] OFS_ENABLE = 5'h04;
    localparam logic [4:0] OFS_TCTRL  = 5'h08;
    localparam logic [4:0] OFS_SRCFLG = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int ENA_GLOBAL_BIT = 7;  // global_enable_bit
    localparam int TC_TRIG_A   = 0;     // ext_line_a_trigger_sel
    localparam int TC_FLAG_A   = 1;     // ext_line_a_flag
    localparam int TC_TRIG_B   = 2;     // ext_line_b_trigger_sel
    localparam int TC_FLAG_B   = 3;     // ext_line_b_flag
    localparam int TC_TF0      = 5;     // first_timer_overflow_flag
    localparam int TC_TF1      = 7;     // second_timer_overflow_flag
    localparam int SF_RX       = 0;     // uart_rx_done_flag
    localparam int SF_TX       = 1;     // uart_tx_done_flag
    localparam int SF_THIRD_TIMER_EXTERNAL_FLAG     = 6;     // third_timer_external_flag
    localparam int SF_TF2      = 7;     // third_timer_overflow_flag

    // Source index = level bit = enable bit = polling order
    localparam int SRC_EXT_A = 0;
    localparam int SRC_T0    = 1;
    localparam int SRC_EXT_B = 2;
    localparam int SRC_T1    = 3;
    localparam int SRC_UART  = 4;
    localparam int SRC_T2    = 5;

    localparam logic [5:0][15:0] VECTORS = {
        16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [5:0] LEVEL_RST  = 6'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] TCTRL_RST  = 8'h00;
    localparam logic [7:0] SRCFLG_RST = 8'h00;

endpackage

// [rtl/irq_ctrl.sv]
// Two-level, six-source interrupt controller with Avalon-MM registers
//
// What this block does
// - Each source has a software level bit; set selects the high level.
// - Low handler preempted only by high; high handler never preempted.
// - Pending requests at both levels: the high level is granted first.
// - Same-level tie order: lineA, timer1, lineB, timer2, serial, timer3.
// - Flags sampled at the sample phase, polled in the next machine cycle.
// - Withhold call: equal/higher in progress, not last cycle, blocking op.
// - Blocked requests are not remembered; each poll uses fresh samples.
// - Grant asks the core for a call pushing only the program counter.
// - Vectors 0003H,000BH,0013H,001BH,0023H,002BH in polling order.
// - Serial and timer3 flags never auto-cleared; lines only in edge mode.
// - Handler return clears current level's in-progress state.
// - Ordinary subroutine exit leaves in-progress state untouched.
// - Trigger select clear: low pin requests; set: edge triggered.
// - Edge mode: sample high then next sample low sets the line flag.
// - Request pins are inverted and latched at the sample phase.
// - The call occupies two machine cycles.
// - Lone-request latency is above 3 and below 9 machine cycles.
// - Extra wait at most 3 cycles, or 5 after blocking instructions.
// - Serial request = rx OR tx done; timer3 = overflow OR external.
// - Vectoring timer1 or timer2 clears its overflow flag.
// - Global enable clear blocks all; else each source gated by its bit.
// - Software flag writes act as hardware sets or clears, except level-mode line flags, which follow the pin.
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps

module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        extRequestPinA_n,
    input  wire logic        extRequestPinB_n,
    input  wire logic        firstTimerOvf,
    input  wire logic        secondTimerOvf,
    input  wire logic        thirdTimerOvf,
    input  wire logic        thirdTimerExt,
    input  wire logic        uartRxDone,
    input  wire logic        uartTxDone,
    input  wire logic        instrLastCycle,
    input  wire logic        instrBlocking,
    input  wire logic        handlerReturn,
    output logic             hwCallReq,
    output logic      [15:0] hwCallVector,
    output logic             hwCallBusy,
    output logic             machineTick
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [3:0]  phase;
        logic [2:0]  syncA;
        logic [2:0]  syncB;
        logic        pinA;
        logic        pinB;
        logic        prevA;
        logic        prevB;
        logic [5:0]  levelSel;
        logic [7:0]  enableMask;
        logic        trigA;
        logic        trigB;
        logic        extAFlag;
        logic        extBFlag;
        logic        tf0;
        logic        tf1;
        logic        tf2;
        logic        third_timer_external_flag;
        logic        rxDone;
        logic        txDone;
        logic [5:0]  sampleSnap;
        logic [5:0]  pollSnap;
        logic [1:0]  inProg;
        logic [1:0]  callCnt;
        logic        callBusy;
        logic        regTouched;
        logic        callReq;
        logic [15:0] vector;
        logic        tick;
        logic        waitreq;
        logic [31:0] rdata;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic [5:0] hiReq;
    logic [5:0] loReq;
    logic [2:0] hiIdx;
    logic [2:0] loIdx;
    logic [2:0] gIdx;
    logic       grant;
    logic       gLevel;
    logic       canPoll;
    logic       busReq;
    logic       accept;
    logic       wrLow;
    logic       touch;
    logic [5:0] srcReq;

    // Lowest set index wins, giving the fixed polling order
    function automatic logic [2:0] firstSet(input logic [5:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [31:0] readMux(input state_type s,
                                            input logic [4:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            OFS_LEVEL:  r[5:0] = s.levelSel;
            OFS_ENABLE: r[7:0] = s.enableMask & 8'hBF;
            OFS_TCTRL: begin
                r[TC_TRIG_A] = s.trigA;
                r[TC_FLAG_A] = s.extAFlag;
                r[TC_TRIG_B] = s.trigB;
                r[TC_FLAG_B] = s.extBFlag;
                r[TC_TF0]    = s.tf0;
                r[TC_TF1]    = s.tf1;
            end
            OFS_SRCFLG: begin
                r[SF_RX]   = s.rxDone;
                r[SF_TX]   = s.txDone;
                r[SF_THIRD_TIMER_EXTERNAL_FLAG] = s.third_timer_external_flag;
                r[SF_TF2]  = s.tf2;
            end
            OFS_STATUS: begin
                r[1:0]  = s.inProg;
                r[2]    = s.callBusy;
                r[13:8] = s.pollSnap;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb begin
        s_d = s_q;
        s_d.callReq = 1'b0;
        s_d.tick = (s_q.phase == PHASE_LAST - 4'h1);
        if (s_q.phase == PHASE_LAST) begin
            s_d.phase = 4'h0;
        end else begin
            s_d.phase = s_q.phase + 4'h1;
        end

        // Pin synchronisers; the filtered level moves once 2nd and 3rd agree
        s_d.syncA = {s_q.syncA[1:0], extRequestPinA_n};
        s_d.syncB = {s_q.syncB[1:0], extRequestPinB_n};
        if (s_q.syncA[2] == s_q.syncA[1]) begin
            s_d.pinA = s_q.syncA[2];
        end
        if (s_q.syncB[2] == s_q.syncB[1]) begin
            s_d.pinB = s_q.syncB[2];
        end

        // Bus slave: one wait cycle, write lands on the waitrequest-low edge
        busReq = read || write;
        accept = busReq && !s_q.waitreq;
        wrLow  = accept && write && byteenable[0];
        touch  = busReq && (address == OFS_LEVEL || address == OFS_ENABLE);
        if (busReq && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata   = readMux(s_q, address);
        end else begin
            s_d.waitreq = 1'b1;
        end

        if (wrLow) begin
            case (address)
                OFS_LEVEL:  s_d.levelSel = writedata[5:0];
                OFS_ENABLE: s_d.enableMask = writedata[7:0] & 8'hBF;
                OFS_TCTRL: begin
                    s_d.trigA    = writedata[TC_TRIG_A];
                    s_d.extAFlag = writedata[TC_FLAG_A];
                    s_d.trigB    = writedata[TC_TRIG_B];
                    s_d.extBFlag = writedata[TC_FLAG_B];
                    s_d.tf0      = writedata[TC_TF0];
                    s_d.tf1      = writedata[TC_TF1];
                end
                OFS_SRCFLG: begin
                    s_d.rxDone = writedata[SF_RX];
                    s_d.txDone = writedata[SF_TX];
                    s_d.third_timer_external_flag   = writedata[SF_THIRD_TIMER_EXTERNAL_FLAG];
                    s_d.tf2    = writedata[SF_TF2];
                end
                default: s_d.rxDone = s_d.rxDone;
            endcase
        end

        // Enable or level access blocks the poll of this machine cycle
        if (s_q.phase == PHASE_LAST) begin
            s_d.regTouched = touch;
        end else if (touch) begin
            s_d.regTouched = 1'b1;
        end

        // Handler return retires the highest active level first
        if (handlerReturn) begin
            if (s_q.inProg[1]) begin
                s_d.inProg[1] = 1'b0;
            end else begin
                s_d.inProg[0] = 1'b0;
            end
        end
        // An ordinary subroutine exit has no strobe here, so it retires
        // nothing and lower requests stay blocked.

        // Poll: stale samples are discarded every cycle, never queued.
        hiReq   = s_q.pollSnap & s_q.levelSel;
        loReq   = s_q.pollSnap & ~s_q.levelSel;
        hiIdx   = firstSet(hiReq);
        loIdx   = firstSet(loReq);
        canPoll = (s_q.phase == PHASE_LAST) && !s_q.callBusy &&
                  instrLastCycle && !instrBlocking &&
                  !s_q.regTouched && !touch;
        grant  = 1'b0;
        gLevel = 1'b0;
        gIdx   = 3'h0;
        if (canPoll && hiReq != 6'h00 && !s_q.inProg[1]) begin
            grant  = 1'b1;
            gLevel = 1'b1;
            gIdx   = hiIdx;
        end else if (canPoll && loReq != 6'h00 &&
                     s_q.inProg == 2'h0) begin
            grant = 1'b1;
            gIdx  = loIdx;
        end

        if (grant) begin
            // Core pushes only the program counter, not the status word
            s_d.callReq          = 1'b1;
            s_d.vector           = VECTORS[gIdx];
            s_d.inProg[gLevel]   = 1'b1;
            s_d.callCnt          = CALL_CYCLES;
            s_d.callBusy         = 1'b1;
            if (gIdx == 3'(SRC_EXT_A) && s_q.trigA) begin
                s_d.extAFlag = 1'b0;
            end
            if (gIdx == 3'(SRC_EXT_B) && s_q.trigB) begin
                s_d.extBFlag = 1'b0;
            end
            if (gIdx == 3'(SRC_T0)) begin
                s_d.tf0 = 1'b0;
            end
            if (gIdx == 3'(SRC_T1)) begin
                s_d.tf1 = 1'b0;
            end
        end else if (s_q.phase == PHASE_LAST && s_q.callCnt != 2'h0) begin
            s_d.callCnt  = s_q.callCnt - 2'h1;
            s_d.callBusy = (s_q.callCnt != 2'h1);
        end

        // Hardware sets come last so they win over any clear
        s_d.tf0    = s_d.tf0 | firstTimerOvf;
        s_d.tf1    = s_d.tf1 | secondTimerOvf;
        s_d.tf2    = s_d.tf2 | thirdTimerOvf;
        s_d.third_timer_external_flag   = s_d.third_timer_external_flag | thirdTimerExt;
        s_d.rxDone = s_d.rxDone | uartRxDone;
        s_d.txDone = s_d.txDone | uartTxDone;

        // Pins latched inverted at the sample phase
        if (s_q.phase == PHASE_SAMPLE) begin
            s_d.prevA = s_q.pinA;
            s_d.prevB = s_q.pinB;
            if (!s_q.trigA) begin
                // Level mode follows the pin; the source owns it
                s_d.extAFlag = !s_q.pinA;
            end else if (s_q.prevA && !s_q.pinA) begin
                s_d.extAFlag = 1'b1;
            end
            if (!s_q.trigB) begin
                s_d.extBFlag = !s_q.pinB;
            end else if (s_q.prevB && !s_q.pinB) begin
                s_d.extBFlag = 1'b1;
            end
        end

        srcReq = {s_d.tf2 | s_d.third_timer_external_flag, s_d.rxDone | s_d.txDone,
                  s_d.tf1, s_d.extBFlag, s_d.tf0, s_d.extAFlag};
        if (s_q.phase == PHASE_SAMPLE) begin
            s_d.sampleSnap = srcReq & s_q.enableMask[5:0] &
                {6{s_q.enableMask[ENA_GLOBAL_BIT]}};
        end
        if (s_q.phase == PHASE_LAST) begin
            s_d.pollSnap = s_q.sampleSnap;
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q            <= '0;
            s_q.syncA      <= 3'h7;
            s_q.syncB      <= 3'h7;
            s_q.pinA       <= 1'b1;
            s_q.pinB       <= 1'b1;
            s_q.prevA      <= 1'b1;
            s_q.prevB      <= 1'b1;
            s_q.levelSel   <= LEVEL_RST;
            s_q.enableMask <= ENABLE_RST;
            s_q.waitreq    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign readdata     = s_q.rdata;
    assign waitrequest  = s_q.waitreq;
    assign hwCallReq    = s_q.callReq;
    assign hwCallVector = s_q.vector;
    assign hwCallBusy   = s_q.callBusy;
    assign machineTick  = s_q.tick;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    call_on_boundary_a: assert property (
        hwCallReq |-> $past(s_q.phase) == PHASE_LAST && s_q.phase == 4'h0)
        else $error("call not at machine cycle boundary");

    high_never_preempt_a: assert property (
        hwCallReq |-> !$past(s_q.inProg[1]))
        else $error("high handler preempted");

    low_only_by_high_a: assert property (
        hwCallReq && $past(s_q.inProg[0]) |-> s_q.inProg[1])
        else $error("low handler preempted by low request");

    call_gated_a: assert property (
        hwCallReq |-> $past(instrLastCycle) && !$past(instrBlocking))
        else $error("call issued while blocked");

    vector_table_a: assert property (
        hwCallReq |-> hwCallVector[2:0] == 3'h3 &&
                      hwCallVector <= 16'h002B)
        else $error("vector outside table");

    serial_kept_a: assert property (
        hwCallReq && hwCallVector == 16'h0023 && !$past(wrLow) |->
            (s_q.rxDone || !$past(s_q.rxDone)) &&
            (s_q.txDone || !$past(s_q.txDone)))
        else $error("serial flags cleared on vectoring");

    timer_clear_a: assert property (
        hwCallReq && hwCallVector == 16'h000B && !$past(firstTimerOvf)
            |-> !s_q.tf0)
        else $error("first timer flag kept after vectoring");

    call_spacing_a: assert property (
        hwCallReq |-> hwCallBusy ##1 (!hwCallReq)[*8])
        else $error("second call inside call cycles");

    return_retire_a: assert property (
        handlerReturn && s_q.inProg == 2'h3 |=> s_q.inProg[1] == 1'b0 &&
            s_q.inProg[0])
        else $error("return did not retire highest level");

    edge_set_a: assert property (
        s_q.phase == PHASE_SAMPLE && s_q.trigA && s_q.prevA &&
            !s_q.pinA |=> s_q.extAFlag)
        else $error("edge on line A not flagged");

    global_gate_a: assert property (
        s_q.phase == PHASE_SAMPLE && !s_q.enableMask[ENA_GLOBAL_BIT]
            |=> s_q.sampleSnap == 6'h00)
        else $error("request sampled while globally disabled");

endmodule

// [testbench/core_model.sv]
// Core sequencer model that answers the interrupt controller
`timescale 1ns/100ps

module core_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic hwCallBusy,
    input  wire logic stallCore,
    input  wire logic blockCore,
    input  wire logic retire,
    output logic      instrLastCycle,
    output logic      instrBlocking,
    output logic      handlerReturn
);
    logic sent_q;

    // ********************************************************
    // Instruction state seen by the poll
    // ********************************************************
    // A stalled core never reaches the final cycle of its instruction
    assign instrLastCycle = !stallCore;
    assign instrBlocking  = blockCore;

    // ********************************************************
    // Handler return
    // ********************************************************
    // One pulse per request, and never while the call is still running
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sent_q        <= 1'b0;
            handlerReturn <= 1'b0;
        end else begin
            handlerReturn <= retire && !sent_q && !hwCallBusy;
            sent_q        <= retire && (sent_q || !hwCallBusy);
        end
    end
endmodule

// [testbench/irq_ctrl_bench.sv]
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/100ps

module irq_ctrl_bench;
    import irq_ctrl_pkg::*;

    logic        ref_clk, rst, read, write, hwCallReq, hwCallBusy;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, q;
    logic        waitrequest, machineTick, pinA_n, pinB_n;
    logic        instrLastCycle, instrBlocking, handlerReturn;
    logic        stallCore, blockCore, retire;
    logic [15:0] hwCallVector;
    logic [5:0]  pulse;
    int          errTotal, compares, cycles, n;
    logic [4:0]  swOfs [6] = '{OFS_TCTRL, OFS_TCTRL, OFS_TCTRL,
                               OFS_TCTRL, OFS_SRCFLG, OFS_SRCFLG};
    logic [7:0]  swVal [6] = '{8'h07, 8'h25, 8'h0D, 8'h85, 8'h01, 8'h40};
    logic [7:0]  hwFlg [6] = '{8'h00, 8'h00, 8'h80, 8'h40, 8'h01, 8'h02};
    logic [15:0] hwVec [6] = '{16'h000B, 16'h001B, 16'h002B,
                               16'h002B, 16'h0023, 16'h0023};

    irq_ctrl uut (
        .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(4'hF), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .extRequestPinA_n(pinA_n), .extRequestPinB_n(pinB_n),
        .firstTimerOvf(pulse[0]), .secondTimerOvf(pulse[1]),
        .thirdTimerOvf(pulse[2]), .thirdTimerExt(pulse[3]),
        .uartRxDone(pulse[4]), .uartTxDone(pulse[5]),
        .instrLastCycle(instrLastCycle), .instrBlocking(instrBlocking),
        .handlerReturn(handlerReturn), .hwCallReq(hwCallReq),
        .hwCallVector(hwCallVector), .hwCallBusy(hwCallBusy),
        .machineTick(machineTick)
    );

    core_model core (
        .ref_clk(ref_clk), .rst(rst), .hwCallBusy(hwCallBusy),
        .stallCore(stallCore), .blockCore(blockCore), .retire(retire),
        .instrLastCycle(instrLastCycle), .instrBlocking(instrBlocking),
        .handlerReturn(handlerReturn)
    );

    always #25 ref_clk = !ref_clk;

    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d);
        @(posedge ref_clk);
        address   <= a;
        write     <= wr;
        read      <= !wr;
        writedata <= {24'h0, d};
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        check("register", q, exp);
    endtask

    task automatic call_chk(input logic [15:0] vec);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hwCallReq !== 1'b1 && n < 80);
        check("call seen", hwCallReq, 1'b1);
        check("vector", hwCallVector, vec);
        check("busy", hwCallBusy, 1'b1);
    endtask

    task automatic quiet();
        n = 0;
        repeat (48) begin
            @(posedge ref_clk);
            if (hwCallReq === 1'b1) n++;
        end
        check("unexpected call", n, 0);
    endtask

    // Returns at the pulse, so a call that follows at once is not missed
    task automatic ret();
        retire <= 1'b1;
        do @(posedge ref_clk); while (handlerReturn !== 1'b1);
        retire <= 1'b0;
    endtask

    // Hang guard well above the length of the whole sequence
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errTotal++;
            wrap_up();
        end
    end

    // ********************************************************
    // Test sequence
    // ********************************************************
    initial begin
        {ref_clk, read, write, stallCore, blockCore, retire} = '0;
        {address, writedata, pulse, errTotal, compares, cycles} = '0;
        {rst, pinA_n, pinB_n} = 3'b111;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 24; a += 4) rd_chk(5'(a), 32'h0);
        bus(1'b1, OFS_LEVEL, 8'hFF);
        rd_chk(OFS_LEVEL, 32'h3F);
        bus(1'b1, OFS_LEVEL, 8'h00);
        do @(posedge ref_clk); while (machineTick !== 1'b1);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (machineTick !== 1'b1 && n < 20);
        check("machine cycle", n, 12);
        bus(1'b1, OFS_ENABLE, 8'hBF);
        bus(1'b1, OFS_TCTRL, 8'h05);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, swOfs[i], swVal[i]);
            call_chk(VECTORS[i]);
            rd_chk(OFS_TCTRL, 32'h05);
            rd_chk(OFS_SRCFLG,
                   swOfs[i] == OFS_SRCFLG ? swVal[i] : 8'h0);
            bus(1'b1, OFS_SRCFLG, 8'h00);
            ret();
        end
        for (int i = 0; i < 6; i++) begin
            pulse[i] <= 1'b1;
            @(posedge ref_clk);
            pulse[i] <= 1'b0;
            call_chk(hwVec[i]);
            rd_chk(OFS_SRCFLG, hwFlg[i]);
            bus(1'b1, OFS_SRCFLG, 8'h00);
            ret();
        end
        // Tie break, then same-level request held off by its peer
        bus(1'b1, OFS_TCTRL, 8'hA5);
        call_chk(16'h000B);
        quiet();
        ret();
        call_chk(16'h001B);
        ret();
        // Timer two raised to the high level
        bus(1'b1, OFS_LEVEL, 8'h08);
        bus(1'b1, OFS_TCTRL, 8'hA5);
        call_chk(16'h001B);
        quiet();
        ret();
        call_chk(16'h000B);
        bus(1'b1, OFS_TCTRL, 8'h85);
        call_chk(16'h001B);
        // Let busy drop and the polled snapshot empty before reading
        repeat (36) @(posedge ref_clk);
        rd_chk(OFS_STATUS, 32'h3);
        ret();
        rd_chk(OFS_STATUS, 32'h1);
        ret();
        rd_chk(OFS_STATUS, 32'h0);
        bus(1'b1, OFS_LEVEL, 8'h00);
        // Poll blocked by the core, flag withdrawn meanwhile
        stallCore <= 1'b1;
        bus(1'b1, OFS_TCTRL, 8'h25);
        quiet();
        bus(1'b1, OFS_TCTRL, 8'h05);
        // The poll still sees the old sample for up to two machine cycles
        repeat (24) @(posedge ref_clk);
        stallCore <= 1'b0;
        quiet();
        blockCore <= 1'b1;
        bus(1'b1, OFS_TCTRL, 8'h25);
        quiet();
        blockCore <= 1'b0;
        call_chk(16'h000B);
        ret();
        bus(1'b1, OFS_ENABLE, 8'h3F);
        bus(1'b1, OFS_TCTRL, 8'h25);
        quiet();
        bus(1'b1, OFS_ENABLE, 8'hBD);
        quiet();
        bus(1'b1, OFS_ENABLE, 8'hBF);
        call_chk(16'h000B);
        ret();
        // Line A level driven, line B edge driven from the pins
        bus(1'b1, OFS_TCTRL, 8'h04);
        pinA_n <= 1'b0;
        call_chk(16'h0003);
        repeat (24) @(posedge ref_clk);
        pinA_n <= 1'b1;
        repeat (48) @(posedge ref_clk);
        rd_chk(OFS_TCTRL, 32'h04);
        ret();
        quiet();
        pinB_n <= 1'b0;
        call_chk(16'h0013);
        rd_chk(OFS_TCTRL, 32'h04);
        ret();
        quiet();
        pinB_n <= 1'b1;
        wrap_up();
    end
endmodule
